// ### design/cflt_core.sv
`timescale 1ns/100ps
`include "cflt_params.svh"

module cflt_core
  import cflt_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Variant strap: high on the twelve-channel part
  input  wire logic        twelve_ch,
  // Management register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // Deglitched fault levels, bit n is monitored_input n+1
  input  wire logic [11:0] uv_fault,
  input  wire logic [11:0] ov_fault,
  // Nonvolatile log writer
  input  wire logic        log_done,
  output logic             log_start,
  output logic             log_store_flags,
  output logic             log_store_adc,
  output logic      [11:0] log_flags,
  // Status and supply control
  output logic             supply_off,
  output logic             log_locked
);

  // Configuration registers.
  logic [7:0]  content_reg;
  logic [7:0]  content_next;
  logic [7:0]  uv_low_reg;
  logic [7:0]  uv_low_next;
  logic [7:0]  uv_hi_ov_reg;
  logic [7:0]  uv_hi_ov_next;
  logic [7:0]  ov_mid_reg;
  logic [7:0]  ov_mid_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        rvalid_reg;
  logic        rvalid_next;

  // Logger state.
  cflt_state_t state_reg;
  cflt_state_t state_next;
  logic        start_reg;
  logic        start_next;
  logic        sflags_reg;
  logic        sflags_next;
  logic        sadc_reg;
  logic        sadc_next;
  logic [11:0] flags_reg;
  logic [11:0] flags_next;
  logic        off_reg;
  logic        off_next;
  logic        locked_reg;
  logic        locked_next;

  logic [11:0] uv_en;
  logic [11:0] ov_en;
  logic [11:0] uv_hit;
  logic [11:0] ov_hit;
  logic        critical;
  logic        unlock_wr;
  logic        wr_ok;

  function automatic logic [7:0] read_mux(input logic [7:0] a);
    case (a)
      `CFLT_OFS_CONTENT:  read_mux = {6'h00, content_reg[1:0]};
      `CFLT_OFS_UV_LOW:   read_mux = uv_low_reg;
      `CFLT_OFS_UV_HI_OV: read_mux = uv_hi_ov_reg;
      `CFLT_OFS_OV_MID:   read_mux = {3'h0, ov_mid_reg[4:0]};
      `CFLT_OFS_UNLOCK:   read_mux = {6'h00, log_locked, 1'b0};
      default:            read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // Enable maps. Channels beyond the eight-channel part stay idle unless
  // the strap says the inputs exist, so a floating input cannot log.
  always_comb
  begin
    uv_en        = 12'h000;
    ov_en        = 12'h000;
    uv_en[7:0]   = uv_low_reg; // R2 R7
    uv_en[11:8]  = uv_hi_ov_reg[`CFLT_UV_HI_MSB:0] & {4{twelve_ch}}; // R3
    ov_en[3:0]   = uv_hi_ov_reg[7:`CFLT_OV_LO_LSB]; // R4 R7
    ov_en[7:4]   = ov_mid_reg[3:0]; // R5
    ov_en[8]     = ov_mid_reg[`CFLT_OV_MID_MSB] & twelve_ch; // R6
    uv_hit       = uv_fault & uv_en;
    ov_hit       = ov_fault & ov_en;
    critical     = |{uv_hit, ov_hit};
  end

  // Register port.
  always_comb
  begin
    wr_ok         = reg_wr & clk_en;
    content_next  = content_reg;
    uv_low_next   = uv_low_reg;
    uv_hi_ov_next = uv_hi_ov_reg;
    ov_mid_next   = ov_mid_reg;
    unlock_wr     = 1'b0;
    rdata_next    = rdata_reg;
    rvalid_next   = 1'b0;
    if (wr_ok)
    begin
      case (reg_addr)
        `CFLT_OFS_CONTENT:  content_next  = {6'h00, reg_wdata[1:0]};
        `CFLT_OFS_UV_LOW:   uv_low_next   = reg_wdata;
        `CFLT_OFS_UV_HI_OV: uv_hi_ov_next = reg_wdata;
        `CFLT_OFS_OV_MID:   ov_mid_next   = {3'h0, reg_wdata[4:0]};
        `CFLT_OFS_UNLOCK:   unlock_wr = reg_wdata[`CFLT_UNLOCK_BIT]; // R9
        default:            unlock_wr = 1'b0;
      endcase
    end
    if (reg_rd)
    begin
      rdata_next  = read_mux(reg_addr);
      rvalid_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      content_reg  <= `CFLT_RST_CONTENT;
      uv_low_reg   <= `CFLT_RST_ENABLE;
      uv_hi_ov_reg <= `CFLT_RST_ENABLE;
      ov_mid_reg   <= `CFLT_RST_ENABLE;
      rdata_reg    <= 8'h00;
      rvalid_reg   <= 1'b0;
    end
    else if (clk_en)
    begin
      content_reg  <= content_next;
      uv_low_reg   <= uv_low_next;
      uv_hi_ov_reg <= uv_hi_ov_next;
      ov_mid_reg   <= ov_mid_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
    end
  end

  // Logger sequence. Supplies go off on any enabled fault even while the
  // log is locked; only the transfer is withheld, so old data survives.
  always_comb
  begin
    state_next  = state_reg;
    start_next  = 1'b0;
    sflags_next = sflags_reg;
    sadc_next   = sadc_reg;
    flags_next  = flags_reg;
    off_next    = off_reg;
    if (critical)
    begin
      off_next = 1'b1; // R8
    end
    case (state_reg)
      CFLT_IDLE:
      begin
        if (critical && content_reg[1:0] != CFLT_STORE_NONE)
        begin
          state_next  = CFLT_LOGGING; // R8
          start_next  = 1'b1;
          flags_next  = uv_hit | ov_hit;
          sflags_next = (content_reg[1:0] == CFLT_STORE_BOTH) ||
                        (content_reg[1:0] == CFLT_STORE_FLAGS); // R1
          sadc_next   = (content_reg[1:0] == CFLT_STORE_BOTH) ||
                        (content_reg[1:0] == CFLT_STORE_ADC); // R1
        end
        else if (unlock_wr && !critical)
        begin
          off_next = 1'b0;
        end
      end
      CFLT_LOGGING:
      begin
        if (log_done)
        begin
          state_next = CFLT_LOCKED; // R9
        end
      end
      CFLT_LOCKED:
      begin
        if (unlock_wr)
        begin
          state_next = CFLT_IDLE; // R9
          off_next   = critical;
        end
      end
      default:
      begin
        state_next = CFLT_IDLE;
      end
    endcase
    // The lock pin is taken from its own flip-flop, not decoded from state.
    locked_next = (state_next == CFLT_LOCKED); // R9
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_reg  <= CFLT_IDLE;
      start_reg  <= 1'b0;
      sflags_reg <= 1'b0;
      sadc_reg   <= 1'b0;
      flags_reg  <= 12'h000;
      off_reg    <= 1'b0;
      locked_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      state_reg  <= state_next;
      start_reg  <= start_next;
      sflags_reg <= sflags_next;
      sadc_reg   <= sadc_next;
      flags_reg  <= flags_next;
      off_reg    <= off_next;
      locked_reg <= locked_next;
    end
  end

  always_comb
  begin
    reg_rdata       = rdata_reg;
    reg_rvalid      = rvalid_reg;
    log_start       = start_reg;
    log_store_flags = sflags_reg;
    log_store_adc   = sadc_reg;
    log_flags       = flags_reg;
    supply_off      = off_reg;
    log_locked      = locked_reg;
  end

endmodule : cflt_core

// ### common/cflt_params.svh
`ifndef CFLT_PARAMS_SVH
`define CFLT_PARAMS_SVH
// Summary of operation
// R1 - Two-bit field picks what the log stores.
// R2 - Low enable bits arm undervoltage inputs 1-8.
// R3 - Second register bits 0-3 arm undervoltage 9-12.
// R4 - Second register bits 4-6 arm overvoltage 1-3.
// R5 - Third register bits 0-3 arm overvoltage 5-8.
// R6 - Third register bit 4 arms overvoltage 9.
// R7 - Bit 6 is input 7; bit 7 overvoltage 4.
// R8 - Enabled fault kills supplies, starts log transfer.
// R9 - Stored log locks; writing unlock bit reopens.

// Register offsets.
`define CFLT_OFS_CONTENT   8'h47
`define CFLT_OFS_UV_LOW    8'h48
`define CFLT_OFS_UV_HI_OV  8'h49
`define CFLT_OFS_OV_MID    8'h4a
`define CFLT_OFS_UNLOCK    8'h5d

// Field positions.
`define CFLT_CONTENT_MSB   1
`define CFLT_UNLOCK_BIT    1
`define CFLT_UV_HI_MSB     3
`define CFLT_OV_LO_LSB     4
`define CFLT_OV_MID_MSB    4

// Reset values of the configuration registers.
`define CFLT_RST_CONTENT   8'h03
`define CFLT_RST_ENABLE    8'h00
`endif

// ### common/cflt_pkg.sv
package cflt_pkg;

  typedef enum logic [1:0]
  {
    CFLT_STORE_BOTH  = 2'h0,
    CFLT_STORE_FLAGS = 2'h1,
    CFLT_STORE_ADC   = 2'h2,
    CFLT_STORE_NONE  = 2'h3
  } cflt_content_t;

  typedef enum logic [1:0]
  {
    CFLT_IDLE,
    CFLT_LOGGING,
    CFLT_LOCKED
  } cflt_state_t;

endpackage : cflt_pkg

// ### tb/cflt_core_asserts.sv
`timescale 1ns/100ps
module cflt_core_asserts (
  // Clock and control
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        twelve_ch,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  // Faults and log
  input wire logic [11:0] uv_fault,
  input wire logic [11:0] ov_fault,
  input wire logic        log_done,
  input wire logic        log_start,
  input wire logic        log_store_flags,
  input wire logic        log_store_adc,
  input wire logic [11:0] log_flags,
  input wire logic        supply_off,
  input wire logic        log_locked
);
  // Frozen cycles are skipped because no state may move in them.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset || !clk_en);
  property p_store; log_start |-> log_store_flags || log_store_adc; endproperty
  a_store: assert property (p_store)
    else $error("start with no content");
  property p_flags; log_start |-> !(log_flags & ~$past(uv_fault | ov_fault));
  endproperty
  a_flags: assert property (p_flags)
    else $error("flag without fault");
  property p_any; log_start |-> supply_off && log_flags != 12'h000; endproperty
  a_any: assert property (p_any)
    else $error("start without shutdown");
  property p_pulse; log_start |=> !log_start; endproperty
  a_pulse: assert property (p_pulse)
    else $error("start too long");
  property p_lock; log_locked |-> !log_start; endproperty
  a_lock: assert property (p_lock)
    else $error("log while locked");
  property p_rise; $rose(log_locked) |-> $past(log_done); endproperty
  a_rise: assert property (p_rise)
    else $error("lock without done");
  property p_fall;
    $fell(supply_off) |-> $past(reg_wr && reg_addr == 8'h5d && reg_wdata[1]);
  endproperty
  a_fall: assert property (p_fall)
    else $error("supply on without unlock");
  property p_rd; reg_rd |=> reg_rvalid; endproperty
  a_rd: assert property (p_rd)
    else $error("read not answered");
  property p_strap;
    log_start && !$past(twelve_ch) |-> log_flags[11:8] == 4'h0;
  endproperty
  a_strap: assert property (p_strap)
    else $error("missing channel logged");
  property p_rdata;
    reg_rd && reg_addr == 8'h47 |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("content field too wide");
endmodule : cflt_core_asserts

bind cflt_core cflt_core_asserts chk (.sys_clk, .reset, .clk_en, .twelve_ch,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .uv_fault,
  .ov_fault, .log_done, .log_start, .log_store_flags, .log_store_adc,
  .log_flags, .supply_off, .log_locked);

// ### tb/cflt_core_tb.sv
`timescale 1ns/100ps
module cflt_core_tb;
  logic        sys_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, log_done = 0;
  logic        clk_en = 1, twelve_ch = 1;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata, m;
  logic [11:0] uv_fault = 0, ov_fault = 0, log_flags, hit;
  logic [23:0] f;
  logic [31:0] x = 32'h0000_22e9;
  logic [7:0]  r [4];
  logic        reg_rvalid, log_start, log_store_flags, log_store_adc;
  logic        supply_off, log_locked, st;
  int          mismatches = 0, comparisons = 0;
  cflt_core dut (.sys_clk, .reset, .clk_en, .twelve_ch, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .uv_fault,
    .ov_fault, .log_done, .log_start, .log_store_flags, .log_store_adc,
    .log_flags, .supply_off, .log_locked);
  initial forever #2.5 sys_clk = ~sys_clk;
  function automatic logic [31:0] rnd;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : rnd
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(string n, logic [11:0] e, logic [11:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  // A spare cycle after each strobe keeps one assignment per time step.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    tick;
    reg_wr = 0;
    tick;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    {reg_rd, reg_addr} = {1'b1, a};
    tick;
    reg_rd = 0;
    chk("rvalid", 1, reg_rvalid);
    chk("rdata", e, reg_rdata);
    tick;
  endtask : rd
  initial
  begin
    repeat (12) tick;
    reset = 0;
    for (int k = 0; k < 4; k++)
      rd(8'(8'h47 + k), k == 0 ? 8'h03 : 8'h00);
    wr(8'h50, 8'hff);
    rd(8'h50, 8'h00);
    // A write while the clock enable is low must leave the register alone.
    clk_en = 0;
    wr(8'h47, 8'h00);
    clk_en = 1;
    rd(8'h47, 8'h03);
    for (int i = 0; i < 80; i++)
    begin
      twelve_ch = 1'(rnd());
      for (int k = 0; k < 4; k++)
      begin
        r[k] = 8'(rnd());
        wr(8'(8'h47 + k), r[k]);
        m = k == 0 ? 8'h03 : k == 3 ? 8'h1f : 8'hff;
        rd(8'(8'h47 + k), r[k] & m);
      end
      f = 24'(rnd() & rnd() & rnd());
      {ov_fault, uv_fault} = f;
      hit = (f[11:0] & {r[2][3:0] & {4{twelve_ch}}, r[1]})
          | (f[23:12] & {3'h0, r[3][4] & twelve_ch, r[3][3:0], r[2][7:4]});
      st = hit != 0 && r[0][1:0] != 2'h3;
      clk_en = 0;
      tick;
      chk("frozen", 0, {log_start, supply_off});
      clk_en = 1;
      tick;
      chk("start", st, log_start);
      chk("off", hit != 0, supply_off);
      if (st) chk("flags", hit, log_flags);
      if (st) chk("store", {!r[0][1], !r[0][0]},
                  {log_store_flags, log_store_adc});
      log_done = st;
      tick;
      log_done = 0;
      chk("start", 0, log_start);
      tick;
      chk("lock", st, log_locked);
      chk("start", 0, log_start);
      {ov_fault, uv_fault} = 24'h00_0000;
      wr(8'h5d, 8'h02);
      chk("lock", 0, log_locked);
      chk("off", 0, supply_off);
    end
    // Unlock while the fault persists: supplies stay off and a new log runs.
    wr(8'h47, 8'h01);
    wr(8'h48, 8'hff);
    uv_fault = 12'h001;
    tick;
    chk("start", 1, log_start);
    chk("flags", 12'h001, log_flags);
    chk("store", 12'h002, {log_store_flags, log_store_adc});
    log_done = 1;
    tick;
    log_done = 0;
    tick;
    chk("lock", 1, log_locked);
    rd(8'h5d, 8'h02);
    wr(8'h5d, 8'h02);
    chk("off", 1, supply_off);
    chk("start", 1, log_start);
    chk("lock", 0, log_locked);
    // A reset in mid-transfer must clear start, shutdown and lock, and restore the content and low enable registers.
    {reset, uv_fault} = {1'b1, 12'h000};
    tick;
    tick;
    reset = 0;
    chk("reset", 0, {log_start, supply_off, log_locked});
    rd(8'h47, 8'h03);
    rd(8'h48, 8'h00);
    stop_test;
  end
endmodule : cflt_core_tb
